// *** test_vft_table_access.sv ***
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the VLAN and filter table block.
// ============================================================
module test_vft_table_access;
  import vft_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [16:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] lookup_vid;
  logic lookup_valid, lookup_use_members;
  logic [2:0] lookup_priority, lookup_spanning_tree_group;
  logic [6:0] lookup_filter_group_id, lookup_untag_mask, lookup_member_mask;
  logic [2:0] acl_sel_pidx, acl_priority_value, acl_remap_priority;
  logic [3:0] acl_sel_entry, acl_first_rule_number;
  logic [1:0] acl_match_kind, acl_priority_action_mode, acl_mirror_action_mode;
  logic acl_count_mode, acl_remap_priority_enable, acl_flag_match_on;
  logic [15:0] acl_matching_rules_mask;
  int n_mismatch = 0;
  int comparisons = 0;
  // Every port meets the bench signal of the same name.
  vft_table_access #(.NUM_PORTS(7)) vft_table_access_i (.*);
  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ============================================================
  // Shared tasks.
  task automatic tally_and_finish();
    $display("Mismatches %0d in %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, then one idle edge so strobes never toggle twice at one edge.
  task automatic apb(input logic wr, input logic [16:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(posedge pclk);
  endtask
  // Reads a status bit until it shows the wanted level, within a bounded number of reads.
  task automatic poll(input logic [16:0] a, input int b, input logic want);
    int n;
    for (n = 0; n < 16; n++) begin
      apb(1'b0, a, VFT_ZERO32);
      if (rd[b] === want) break;
    end
    if (n == 16) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  function automatic logic [16:0] va(input logic [14:0] i);
    return {i, 2'b00};
  endfunction
  function automatic logic [16:0] fa(input logic [2:0] p, input logic [7:0] off);
    return {p, 4'h6, off, 2'b00};
  endfunction
  // ============================================================
  // Scenarios.
  task automatic reset_values();
    apb(1'b0, va(VFT_REG_VLAN_CTRL), VFT_ZERO32);
    chk("vlan ctrl", rd, VFT_ZERO32);
    apb(1'b0, fa(3'h3, 8'h10), VFT_ZERO32);
    chk("byte enable", rd, VFT_ZERO32);
    apb(1'b0, va(15'h0105), VFT_ZERO32);
    chk("spare", {err, rd[30:0]}, 32'h8000_0000);
  endtask
  // Writes one VLAN entry, looks it up, wipes the staging and reads it back.
  task automatic vlan_case(input logic [11:0] idx, input logic [31:0] e0, input logic [6:0] e1,
    input logic [6:0] e2);
    apb(1'b1, va(VFT_REG_VLAN_ENTRY0), e0);
    apb(1'b1, va(VFT_REG_VLAN_ENTRY1), 32'(e1));
    apb(1'b1, va(VFT_REG_VLAN_ENTRY2), 32'(e2));
    apb(1'b1, va(VFT_REG_VLAN_INDEX), {20'hA_5A5A, idx});
    apb(1'b1, va(VFT_REG_VLAN_CTRL), 32'h0000_0080);
    poll(va(VFT_REG_VLAN_CTRL), 7, 1'b0);
    lookup_vid <= idx;
    repeat (2) @(posedge pclk);
    chk("lookup e0", {lookup_valid, lookup_use_members, lookup_priority,
      lookup_spanning_tree_group, 17'h0_0000, lookup_filter_group_id}, e0 & 32'hFF00_007F);
    chk("lookup ports", {lookup_untag_mask, lookup_member_mask}, {e1, e2});
    for (int k = 0; k < 3; k++) apb(1'b1, va(VFT_REG_VLAN_ENTRY0 + 15'(k)), VFT_ZERO32);
    apb(1'b1, va(VFT_REG_VLAN_CTRL), 32'h0000_0081);
    apb(1'b0, va(VFT_REG_VLAN_CTRL), VFT_ZERO32);
    chk("start held", 32'(rd[7]), 32'h0000_0001);
    poll(va(VFT_REG_VLAN_CTRL), 7, 1'b0);
    apb(1'b0, va(VFT_REG_VLAN_ENTRY0), VFT_ZERO32);
    chk("entry0", rd, e0 & 32'hFF00_007F);
    apb(1'b0, va(VFT_REG_VLAN_ENTRY2), VFT_ZERO32);
    chk("entry2", rd, 32'(e2));
    apb(1'b0, va(VFT_REG_VLAN_INDEX), VFT_ZERO32);
    chk("index", rd, 32'(idx));
  endtask
  // Loads sixteen staging bytes and the mask, then starts one filter access.
  task automatic acl_cycle(input logic [3:0] ent, input logic [15:0] be, input logic [127:0] d,
    input logic dir);
    for (int k = 0; k < 16; k++) apb(1'b1, fa(3'h3, 8'(k)), 32'(d[127-8*k -: 8]));
    apb(1'b1, fa(3'h3, 8'h10), 32'(be[15:8]));
    apb(1'b1, fa(3'h3, 8'h11), 32'(be[7:0]));
    apb(1'b1, fa(3'h3, 8'h12), {27'h000_0000, dir, ent});
    poll(fa(3'h3, 8'h12), dir ? 6 : 5, 1'b1);
    repeat (2) @(posedge pclk);
  endtask
  task automatic acl_scenario();
    acl_sel_pidx <= 3'h2;
    acl_sel_entry <= 4'h5;
    acl_cycle(4'h5, 16'hFFFF, 128'h0934_1111_1111_1101_2233_AFC0_7745_1234, 1'b1);
    chk("actions", {acl_priority_action_mode, acl_priority_value, acl_remap_priority_enable,
      acl_remap_priority, acl_mirror_action_mode}, {2'h2, 3'h5, 1'b1, 3'h7, 2'h2});
    chk("rule set", acl_matching_rules_mask, 32'h0000_1234);
    chk("port kind", {acl_flag_match_on, acl_match_kind, acl_first_rule_number}, 32'h0000_0079);
    acl_cycle(4'h5, 16'h0009, 128'h0934_1111_1111_1101_2233_AFC0_7745_ABCD, 1'b1);
    chk("reverse mask", acl_matching_rules_mask, 32'h0000_12CD);
    acl_sel_entry <= 4'h6;
    acl_cycle(4'h6, 16'hFFFF, 128'h0010_0000_0000_0000_0000_FFE0_0000_0000, 1'b1);
    chk("count mode", {acl_count_mode, acl_match_kind, acl_priority_action_mode,
      acl_priority_value}, 32'h0000_00A0);
    acl_cycle(4'h5, 16'hFFFF, 128'h0, 1'b0);
    apb(1'b0, fa(3'h3, 8'h0F), VFT_ZERO32);
    chk("read byte f", rd, 32'h0000_00CD);
    apb(1'b0, fa(3'h3, 8'h0A), VFT_ZERO32);
    chk("read byte a", rd, 32'h0000_00AF);
    apb(1'b0, fa(3'h3, 8'h0C), VFT_ZERO32);
    chk("read byte c", rd, VFT_ZERO32);
    acl_sel_pidx <= 3'h7;
    repeat (2) @(posedge pclk);
    chk("absent port", {acl_match_kind, acl_count_mode, acl_flag_match_on}, VFT_ZERO32);
  endtask
  // ============================================================
  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    lookup_vid = '0;
    acl_sel_pidx = '0;
    acl_sel_entry = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    reset_values();
    vlan_case(12'hFFF, 32'hFFFF_FFFF, 7'h2A, 7'h41);
    vlan_case(12'h000, 32'h2B00_0055, 7'h55, 7'h3E);
    acl_scenario();
    tally_and_finish();
  end
endmodule
bind vft_table_access vft_table_access_monitor #(.NUM_PORTS(NUM_PORTS))
  vft_table_access_monitor_i (.*);

// *** vft_pkg.sv ***
// ============================================================
// Shared constants and types for the VLAN and filter table block.
// ============================================================
package vft_pkg;
  // VLAN table geometry.
  localparam int VFT_VID_W = 12;
  localparam int VFT_VLAN_DEPTH = 4096;
  localparam int VFT_PORT_MASK_W = 7;
  // Packed entry width: valid, select, priority, group, filter id, untag, member.
  localparam int VFT_ENTRY_W = 29;
  // Filter table geometry.
  localparam int VFT_ACL_ENTRIES = 16;
  localparam int VFT_ACL_BYTES = 16;
  localparam int VFT_PADDR_W = 17;
  // Register indices; the byte address is four times the index.
  localparam logic [14:0] VFT_REG_VLAN_ENTRY0 = 15'h0100;
  localparam logic [14:0] VFT_REG_VLAN_ENTRY1 = 15'h0101;
  localparam logic [14:0] VFT_REG_VLAN_ENTRY2 = 15'h0102;
  localparam logic [14:0] VFT_REG_VLAN_INDEX = 15'h0103;
  localparam logic [14:0] VFT_REG_VLAN_CTRL = 15'h0104;
  // Per-port window offsets; port number sits above them.
  localparam logic [7:0] VFT_ACL_DATA_PAGE = 8'h60;
  localparam logic [11:0] VFT_ACL_BE_MSB = 12'h0610;
  localparam logic [11:0] VFT_ACL_BE_LSB = 12'h0611;
  localparam logic [11:0] VFT_ACL_CTRL = 12'h0612;
  localparam logic [3:0] VFT_ACL_UNUSED_BYTE = 4'hC;
  // Field positions of VLAN entry register 0.
  localparam int VFT_E0_VALID = 31;
  localparam int VFT_E0_FWD_SEL = 30;
  localparam int VFT_E0_PRI_LSB = 27;
  localparam int VFT_E0_STG_LSB = 24;
  localparam int VFT_E0_FID_LSB = 0;
  // Field positions of the VLAN access control register.
  localparam int VFT_VC_START = 7;
  localparam int VFT_VC_READ = 0;
  // Field positions of the filter access control register.
  localparam int VFT_FC_DIR = 4;
  localparam int VFT_FC_RD_DONE = 5;
  localparam int VFT_FC_WR_DONE = 6;
  // Field positions inside filter data bytes.
  localparam int VFT_B1_KIND_LSB = 4;
  localparam int VFT_B1_ENSEL_LSB = 2;
  localparam int VFT_BA_PM_LSB = 6;
  localparam int VFT_BA_PRI_LSB = 3;
  localparam int VFT_BA_RPE = 2;
  localparam int VFT_BA_RPHI_LSB = 0;
  localparam int VFT_BB_RPLO = 7;
  localparam int VFT_BB_MM_LSB = 5;
  localparam int VFT_B7_FLAG_ON = 0;
  // Match kinds.
  localparam logic [1:0] VFT_KIND_MAC = 2'h1;
  localparam logic [1:0] VFT_KIND_IP = 2'h2;
  localparam logic [1:0] VFT_KIND_PORT = 2'h3;
  // Reset values.
  localparam logic [31:0] VFT_ZERO32 = 32'h0000_0000;
  localparam logic [15:0] VFT_BE_RESET = 16'h0000;
  // Sequencer states.
  typedef enum logic [1:0] {V_IDLE, V_WRITE, V_READ, V_CAPT} vft_vstate_t;
  typedef enum logic {F_IDLE, F_RUN} vft_fstate_t;
endpackage

// *** vft_table_access.sv ***
`timescale 1ns/10ps
// Operation
// - VLAN entry carries a validity flag.
// - Select bit chooses membership list forwarding.
// - VLAN entry stores three-bit priority.
// - VLAN entry stores spanning tree group.
// - VLAN entry stores seven-bit filter group.
// - Per-port egress tag strip mask.
// - Per-port membership mask, bit 0 port 1.
// - Twelve-bit index equals VLAN identifier.
// - Write sequence; start bit self-clears.
// - Read sequence; start bit self-clears.
// - Read result lands in entry registers.
// - Table holds 4k entries.
// - Sixteen filter entries per port, indirect.
// - Filter registers live in per-port window.
// - Sixteen-bit byte enable selects bytes.
// - Byte enable bits map in reverse.
// - Byte C unused; enable bit 3 ignored.
// - Priority mode in byte A bits 7:6.
// - Priority value in byte A bits 5:3.
// - Remap priority split across bytes A, B.
// - Mirror mode in byte B bits 6:5.
// - One control write with dir clear reads.
// - One control write with dir set writes.
module vft_table_access #(
  parameter int NUM_PORTS = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vft_pkg::VFT_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [vft_pkg::VFT_VID_W-1:0] lookup_vid,
  output logic lookup_valid,
  output logic lookup_use_members,
  output logic [2:0] lookup_priority,
  output logic [2:0] lookup_spanning_tree_group,
  output logic [6:0] lookup_filter_group_id,
  output logic [6:0] lookup_untag_mask,
  output logic [6:0] lookup_member_mask,
  input wire logic [2:0] acl_sel_pidx,
  input wire logic [3:0] acl_sel_entry,
  output logic [1:0] acl_match_kind,
  output logic acl_count_mode,
  output logic [3:0] acl_first_rule_number,
  output logic [1:0] acl_priority_action_mode,
  output logic [2:0] acl_priority_value,
  output logic acl_remap_priority_enable,
  output logic [2:0] acl_remap_priority,
  output logic [1:0] acl_mirror_action_mode,
  output logic [15:0] acl_matching_rules_mask,
  output logic acl_flag_match_on
);
  import vft_pkg::*;

  // ============================================================
  // Helper functions
  // ============================================================
  // Data byte k follows enable bit 15-k; byte C never transfers.
  function automatic logic be_hit(input logic [15:0] mask, input int k);
    logic [3:0] kk;
    kk = 4'(k);
    be_hit = (kk != VFT_ACL_UNUSED_BYTE) && mask[15-k];
  endfunction

  // Port number 1..N becomes an array index 0..N-1.
  function automatic logic [2:0] port_to_idx(input logic [2:0] pn);
    port_to_idx = 3'(pn - 3'd1);
  endfunction

  // ============================================================
  // APB address decode
  // ============================================================
  wire [14:0] acc_idx = paddr[VFT_PADDR_W-1:2];
  wire [2:0] acc_port = acc_idx[14:12];
  wire [11:0] acc_off = acc_idx[11:0];
  wire [2:0] acc_pidx = port_to_idx(acc_port);
  // Filter window belongs to ports 1..NUM_PORTS only.
  wire acl_port_ok = (acc_port != 3'd0) && (32'(acc_port) <= NUM_PORTS);
  wire hit_acl_data = acl_port_ok && (acc_off[11:4] == VFT_ACL_DATA_PAGE);
  wire hit_be_msb = acl_port_ok && (acc_off == VFT_ACL_BE_MSB);
  wire hit_be_lsb = acl_port_ok && (acc_off == VFT_ACL_BE_LSB);
  wire hit_acl_ctrl = acl_port_ok && (acc_off == VFT_ACL_CTRL);
  wire hit_e0 = (acc_idx == VFT_REG_VLAN_ENTRY0);
  wire hit_e1 = (acc_idx == VFT_REG_VLAN_ENTRY1);
  wire hit_e2 = (acc_idx == VFT_REG_VLAN_ENTRY2);
  wire hit_idx = (acc_idx == VFT_REG_VLAN_INDEX);
  wire hit_vctrl = (acc_idx == VFT_REG_VLAN_CTRL);
  wire hit_any = hit_acl_data | hit_be_msb | hit_be_lsb | hit_acl_ctrl |
                 hit_e0 | hit_e1 | hit_e2 | hit_idx | hit_vctrl;
  // Access phase strobes; a write takes effect at the access edge.
  wire acc_phase = psel & penable;
  wire setup_phase = psel & ~penable;
  wire wr_en = acc_phase & pwrite & hit_any;

  // ============================================================
  // VLAN side registers
  // ============================================================
  logic [31:0] ve0_r; // Valid, select, priority, group, filter id.
  logic [6:0] ve1_r; // Egress tag strip mask.
  logic [6:0] ve2_r; // Port membership mask.
  logic [VFT_VID_W-1:0] vindex_r; // Entry address, equal to the VLAN identifier.
  logic vstart_r; // Access in progress.
  logic vread_r; // Direction of the pending access.
  vft_vstate_t vstate_r;
  vft_vstate_t vstate_nxt;
  logic [VFT_ENTRY_W-1:0] ram_rdata;
  logic [VFT_ENTRY_W-1:0] ram_bdata;

  // Entry word packed from the entry registers for the table write.
  wire [VFT_ENTRY_W-1:0] ram_wdata = {ve0_r[VFT_E0_VALID], ve0_r[VFT_E0_FWD_SEL],
                                      ve0_r[VFT_E0_PRI_LSB +: 3],
                                      ve0_r[VFT_E0_STG_LSB +: 3],
                                      ve0_r[VFT_E0_FID_LSB +: 7], ve1_r, ve2_r};
  wire ram_we = (vstate_r == V_WRITE);
  wire vdone = (vstate_r == V_WRITE) || (vstate_r == V_CAPT);
  wire vstart_set = wr_en & hit_vctrl & pwdata[VFT_VC_START];

  // Sequencer: a write takes one cycle, a read two.
  always_comb begin
    case (vstate_r)
      V_IDLE: begin
        if (vstart_r) begin
          vstate_nxt = vread_r ? V_READ : V_WRITE;
        end else begin
          vstate_nxt = V_IDLE;
        end
      end
      V_READ: vstate_nxt = V_CAPT;
      default: vstate_nxt = V_IDLE;
    endcase
  end

  // The sequencer state register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vstate_r <= V_IDLE;
    end else begin
      vstate_r <= vstate_nxt;
    end
  end

  // Start bit: a software set wins over the completion clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vstart_r <= 1'b0;
      vread_r <= 1'b0;
    end else if (vstart_set) begin
      vstart_r <= 1'b1;
      vread_r <= pwdata[VFT_VC_READ];
    end else if (vdone) begin
      vstart_r <= 1'b0;
    end
  end

  // Entry and index registers; a finished read reloads the entry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ve0_r <= VFT_ZERO32;
      ve1_r <= '0;
      ve2_r <= '0;
      vindex_r <= '0;
    end else if (vstate_r == V_CAPT) begin
      ve0_r <= {ram_rdata[28], ram_rdata[27], ram_rdata[26:24], ram_rdata[23:21],
                17'h0_0000, ram_rdata[20:14]};
      ve1_r <= ram_rdata[13:7];
      ve2_r <= ram_rdata[6:0];
    end else if (wr_en) begin
      if (hit_e0) begin
        ve0_r <= pwdata & 32'hFF00_007F;
      end
      if (hit_e1) begin
        ve1_r <= pwdata[6:0];
      end
      if (hit_e2) begin
        ve2_r <= pwdata[6:0];
      end
      if (hit_idx) begin
        vindex_r <= pwdata[VFT_VID_W-1:0];
      end
    end
  end

  // Table storage with a lookup port that serves the forwarding logic.
  vft_vlan_ram #(
    .DEPTH(VFT_VLAN_DEPTH),
    .AW(VFT_VID_W),
    .DW(VFT_ENTRY_W)
  ) u_vlan_ram (
    .pclk(pclk),
    .presetn(presetn),
    .a_we(ram_we),
    .a_addr(vindex_r),
    .a_wdata(ram_wdata),
    .a_rdata(ram_rdata),
    .b_addr(lookup_vid),
    .b_rdata(ram_bdata)
  );

  // Lookup result fields, sliced straight from the read flops.
  assign lookup_valid = ram_bdata[28];
  assign lookup_use_members = ram_bdata[27];
  assign lookup_priority = ram_bdata[26:24];
  assign lookup_spanning_tree_group = ram_bdata[23:21];
  assign lookup_filter_group_id = ram_bdata[20:14];
  assign lookup_untag_mask = ram_bdata[13:7];
  assign lookup_member_mask = ram_bdata[6:0];

  // ============================================================
  // Filter table registers and storage
  // ============================================================
  logic [7:0] acl_mem [NUM_PORTS][VFT_ACL_ENTRIES][VFT_ACL_BYTES];
  logic [7:0] acl_data_r [NUM_PORTS][VFT_ACL_BYTES]; // Staging bytes per port.
  logic [15:0] acl_be_r [NUM_PORTS]; // Byte enable mask per port.
  logic [3:0] acl_entry_r [NUM_PORTS]; // Last requested entry number.
  logic acl_dir_r [NUM_PORTS]; // Last direction, 1 for write.
  logic acl_rdone_r [NUM_PORTS]; // Read finished.
  logic acl_wdone_r [NUM_PORTS]; // Write finished.
  vft_fstate_t fstate_r;
  logic [2:0] fop_pidx_r; // Port served by the running access.

  // A control write starts an access only when the sequencer is free.
  wire acl_go = wr_en & hit_acl_ctrl & (fstate_r == F_IDLE);
  wire fop_run = (fstate_r == F_RUN);

  // The filter sequencer needs one cycle to move the enabled bytes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fstate_r <= F_IDLE;
      fop_pidx_r <= '0;
    end else begin
      case (fstate_r)
        F_IDLE: begin
          if (acl_go) begin
            fstate_r <= F_RUN;
            fop_pidx_r <= acc_pidx;
          end
        end
        default: fstate_r <= F_IDLE;
      endcase
    end
  end

  // Table storage takes the enabled bytes of a write access.
  always_ff @(posedge pclk) begin
    for (int k = 0; k < VFT_ACL_BYTES; k++) begin
      if (fop_run && acl_dir_r[fop_pidx_r] && be_hit(acl_be_r[fop_pidx_r], k)) begin
        acl_mem[fop_pidx_r][acl_entry_r[fop_pidx_r]][k] <= acl_data_r[fop_pidx_r][k];
      end
    end
  end

  // Per-port control, mask and staging bytes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        acl_be_r[p] <= VFT_BE_RESET;
        acl_entry_r[p] <= '0;
        acl_dir_r[p] <= 1'b0;
        acl_rdone_r[p] <= 1'b0;
        acl_wdone_r[p] <= 1'b0;
        for (int k = 0; k < VFT_ACL_BYTES; k++) begin
          acl_data_r[p][k] <= '0;
        end
      end
    end else begin
      // Software writes to the staging bytes; byte C holds nothing.
      if (wr_en && hit_acl_data && (acc_off[3:0] != VFT_ACL_UNUSED_BYTE)) begin
        acl_data_r[acc_pidx][acc_off[3:0]] <= pwdata[7:0];
      end
      if (wr_en && hit_be_msb) begin
        acl_be_r[acc_pidx][15:8] <= pwdata[7:0];
      end
      if (wr_en && hit_be_lsb) begin
        acl_be_r[acc_pidx][7:0] <= pwdata[7:0];
      end
      // A new access clears both completion flags of its port.
      if (acl_go) begin
        acl_entry_r[acc_pidx] <= pwdata[3:0];
        acl_dir_r[acc_pidx] <= pwdata[VFT_FC_DIR];
        acl_rdone_r[acc_pidx] <= 1'b0;
        acl_wdone_r[acc_pidx] <= 1'b0;
      end
      // Completion loads enabled bytes on a read and raises status.
      if (fop_run) begin
        if (acl_dir_r[fop_pidx_r]) begin
          acl_wdone_r[fop_pidx_r] <= 1'b1;
        end else begin
          acl_rdone_r[fop_pidx_r] <= 1'b1;
          for (int k = 0; k < VFT_ACL_BYTES; k++) begin
            if (be_hit(acl_be_r[fop_pidx_r], k)) begin
              acl_data_r[fop_pidx_r][k] <=
                acl_mem[fop_pidx_r][acl_entry_r[fop_pidx_r]][k];
            end
          end
        end
      end
    end
  end

  // ============================================================
  // Decoded view of one selected filter entry
  // ============================================================
  wire [7:0] sel_b0 = acl_mem[acl_sel_pidx][acl_sel_entry][0];
  wire [7:0] sel_b1 = acl_mem[acl_sel_pidx][acl_sel_entry][1];
  wire [7:0] sel_b7 = acl_mem[acl_sel_pidx][acl_sel_entry][7];
  wire [7:0] sel_ba = acl_mem[acl_sel_pidx][acl_sel_entry][10];
  wire [7:0] sel_bb = acl_mem[acl_sel_pidx][acl_sel_entry][11];
  wire [7:0] sel_be = acl_mem[acl_sel_pidx][acl_sel_entry][14];
  wire [7:0] sel_bf = acl_mem[acl_sel_pidx][acl_sel_entry][15];
  wire sel_ok = (32'(acl_sel_pidx) < NUM_PORTS);
  wire [1:0] sel_kind = sel_b1[VFT_B1_KIND_LSB +: 2];
  // Counting mode reuses the action bytes as a counter.
  wire sel_count = (sel_kind == VFT_KIND_MAC) && (sel_b1[VFT_B1_ENSEL_LSB +: 2] == 2'h0);

  // Registered decode; out-of-range selections read as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acl_match_kind <= '0;
      acl_count_mode <= 1'b0;
      acl_first_rule_number <= '0;
      acl_priority_action_mode <= '0;
      acl_priority_value <= '0;
      acl_remap_priority_enable <= 1'b0;
      acl_remap_priority <= '0;
      acl_mirror_action_mode <= '0;
      acl_matching_rules_mask <= '0;
      acl_flag_match_on <= 1'b0;
    end else begin
      acl_match_kind <= sel_ok ? sel_kind : 2'h0;
      acl_count_mode <= sel_ok & sel_count;
      acl_first_rule_number <= sel_ok ? sel_b0[3:0] : 4'h0;
      acl_priority_action_mode <= (sel_ok && !sel_count) ? sel_ba[VFT_BA_PM_LSB +: 2] : 2'h0;
      acl_priority_value <= (sel_ok && !sel_count) ? sel_ba[VFT_BA_PRI_LSB +: 3] : 3'h0;
      acl_remap_priority_enable <= sel_ok & ~sel_count & sel_ba[VFT_BA_RPE];
      acl_remap_priority <= (sel_ok && !sel_count) ?
        {sel_ba[VFT_BA_RPHI_LSB +: 2], sel_bb[VFT_BB_RPLO]} : 3'h0;
      acl_mirror_action_mode <= (sel_ok && !sel_count) ? sel_bb[VFT_BB_MM_LSB +: 2] : 2'h0;
      acl_matching_rules_mask <= sel_ok ? {sel_be, sel_bf} : 16'h0000;
      acl_flag_match_on <= sel_ok & (sel_kind == VFT_KIND_PORT) & sel_b7[VFT_B7_FLAG_ON];
    end
  end

  // ============================================================
  // APB read data and answer
  // ============================================================
  wire [7:0] acl_ctrl_rd = {1'b0, acl_wdone_r[acc_pidx], acl_rdone_r[acc_pidx],
                            acl_dir_r[acc_pidx], acl_entry_r[acc_pidx]};
  wire [7:0] acl_byte_rd = (acc_off[3:0] == VFT_ACL_UNUSED_BYTE) ? 8'h00 :
                           acl_data_r[acc_pidx][acc_off[3:0]];
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;

  // Read selection; unmapped and reserved bits read as zero.
  always_comb begin
    rd_mux = VFT_ZERO32;
    if (hit_e0) begin
      rd_mux = ve0_r;
    end else if (hit_e1) begin
      rd_mux = {25'h000_0000, ve1_r};
    end else if (hit_e2) begin
      rd_mux = {25'h000_0000, ve2_r};
    end else if (hit_idx) begin
      rd_mux = {20'h0_0000, vindex_r};
    end else if (hit_vctrl) begin
      rd_mux = {24'h00_0000, vstart_r, 6'h00, vread_r};
    end else if (hit_acl_data) begin
      rd_mux = {24'h00_0000, acl_byte_rd};
    end else if (hit_be_msb) begin
      rd_mux = {24'h00_0000, acl_be_r[acc_pidx][15:8]};
    end else if (hit_be_lsb) begin
      rd_mux = {24'h00_0000, acl_be_r[acc_pidx][7:0]};
    end else if (hit_acl_ctrl) begin
      rd_mux = {24'h00_0000, acl_ctrl_rd};
    end
  end

  // Read data is captured in the setup cycle and held through access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= VFT_ZERO32;
    end else if (setup_phase) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = acc_phase & ~hit_any;
endmodule

// *** vft_table_access_monitor.sv ***
`timescale 1ns/10ps
// ============================================================
// Port checker for the table access block.
// ============================================================
module vft_table_access_monitor
  import vft_pkg::*;
#(
  parameter int NUM_PORTS = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vft_pkg::VFT_PADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [2:0] acl_sel_pidx,
  input wire logic [1:0] acl_match_kind,
  input wire logic acl_count_mode,
  input wire logic [1:0] acl_priority_action_mode,
  input wire logic [2:0] acl_priority_value,
  input wire logic acl_flag_match_on
);
  // Word index of the bus address; the spare index decodes to nothing.
  wire logic [14:0] idx = paddr[16:2];
  wire logic rd_setup = psel && !penable && !pwrite;
  localparam logic [14:0] SPARE = 15'h0105;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ============================================================
  // Bus answers.
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("error flag outside an access phase");
  spare_err_a: assert property (psel && penable && idx == SPARE |-> pslverr)
    else $error("unmapped access not flagged");
  index_ok_a: assert property (psel && penable && idx == VFT_REG_VLAN_INDEX |-> !pslverr)
    else $error("index register access flagged");
  spare_zero_a: assert property (rd_setup && idx == SPARE |=> prdata == VFT_ZERO32)
    else $error("unmapped read not zero");
  index_width_a: assert property (rd_setup && idx == VFT_REG_VLAN_INDEX |=> prdata[31:12] == '0)
    else $error("index wider than twelve bits");
  untag_width_a: assert property (rd_setup && idx == VFT_REG_VLAN_ENTRY1 |=> prdata[31:7] == '0)
    else $error("untag mask wider than seven bits");
  byte_c_zero_a: assert property (rd_setup && idx[11:0] == 12'h060C && idx[14:12] != 3'h0
    |=> prdata == VFT_ZERO32)
    else $error("unused filter byte not zero");
  // ============================================================
  // Decoded filter fields.
  count_quiet_a: assert property (acl_count_mode |-> acl_match_kind == VFT_KIND_MAC
    && acl_priority_action_mode == 2'h0 && acl_priority_value == 3'h0)
    else $error("count mode shows action fields");
  flag_kind_a: assert property (acl_flag_match_on |-> acl_match_kind == VFT_KIND_PORT)
    else $error("flag match outside port kind");
  bad_port_a: assert property (acl_sel_pidx >= NUM_PORTS |=> acl_match_kind == 2'h0
    && !acl_count_mode && !acl_flag_match_on)
    else $error("absent port decodes fields");
endmodule

// *** vft_vlan_ram.sv ***
`timescale 1ns/10ps
// ============================================================
// VLAN table storage: one read/write port, one lookup read port.
// ============================================================
module vft_vlan_ram #(
  parameter int DEPTH = 4096,
  parameter int AW = 12,
  parameter int DW = 29
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  input wire logic [AW-1:0] b_addr,
  output logic [DW-1:0] b_rdata
);
  // Entry storage; contents are undefined until software fills them.
  logic [DW-1:0] mem [DEPTH];

  // The write port updates one entry per cycle.
  always_ff @(posedge pclk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end

  // Both read ports have one cycle of latency.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end
endmodule
